// ===== pmt_pkg.sv
// constants and types shared by the protocol translator
`default_nettype none
package pmt_pkg;
  // native protocol opcodes
  localparam logic [7:0]  NAT_PRI_READ    = 8'h20;
  localparam logic [7:0]  NAT_NP_READ     = 8'h00;
  localparam logic [7:0]  NAT_NP_RREAD    = 8'h04;
  localparam logic [7:0]  NAT_PRI_WRITE   = 8'h1E;
  localparam logic [7:0]  NAT_NP_WRITE    = 8'h02;
  localparam logic [7:0]  NAT_PRI_PRINT   = 8'h22;
  localparam logic [7:0]  NAT_PRINT_REPLY = 8'h92;
  // modbus function codes
  localparam logic [7:0]  MB_RD_COILS     = 8'h01;
  localparam logic [7:0]  MB_RD_INPUTS    = 8'h02;
  localparam logic [7:0]  MB_RD_HOLD      = 8'h03;
  localparam logic [7:0]  MB_RD_INREG     = 8'h04;
  localparam logic [7:0]  MB_FORCE_COIL   = 8'h05;
  localparam logic [7:0]  MB_PRESET_REG   = 8'h06;
  localparam logic [7:0]  MB_FORCE_COILS  = 8'h0F;
  localparam logic [7:0]  MB_WR_MULTI     = 8'h10;
  localparam logic [7:0]  MB_WRAP         = 8'h11;
  localparam logic [7:0]  MB_MASK_WR      = 8'h16;
  localparam logic [7:0]  MB_RAND_RD      = 8'h64;
  // encapsulation markers
  localparam logic [7:0]  WRAP_QRY_PARAM  = 8'h01;
  localparam logic [7:0]  WRAP_RPL_PARAM  = 8'h02;
  localparam logic [15:0] WRAP_STATUS     = 16'hBAD5;
  localparam logic [7:0]  WRAP_ADDR_TX    = 8'h00;
  localparam logic [7:0]  STAT_COIL_SFX   = 8'h03;
  localparam logic [7:0]  STAT_INPUT_SFX  = 8'h05;
  localparam logic [15:0] MASK_ALL        = 16'hFFFF;
  localparam logic [7:0]  COUNT_ONE       = 8'h01;
  localparam logic [7:0]  REG_BITS        = 8'h10;
  // sizes
  localparam int          TAG_W           = 3;
  localparam int          TAG_N           = 8;
  localparam int          FIFO_DEPTH      = 8;
  // port modes, gray along pass-native-gate-host
  typedef enum logic [1:0] {
    PMT_PORT_PASS    = 2'b00,
    PMT_PORT_NATIVE  = 2'b01,
    PMT_PORT_MB_GATE = 2'b11,
    PMT_PORT_MB_HOST = 2'b10
  } pmt_mode_t;
  // one message descriptor
  typedef struct packed {
    logic             from_mb;   // originated on modbus side
    logic             reply;     // answer, not query
    logic             error;     // error answer
    logic             wrapped;   // carried by encapsulation
    logic [TAG_W-1:0] tag;       // transaction slot
    logic [7:0]       code;      // opcode or function
    logic [15:0]      status;    // status address / transnum
    logic [15:0]      start;     // first register or coil
    logic [7:0]       count;     // registers or coils
    logic [15:0]      mask;      // write bit mask
    logic [15:0]      data;      // first data word
    logic             has_param; // function 17 parameter present
    logic [7:0]       param;     // function 17 parameter
    logic [7:0]       addr_byte; // wrapped modbus address byte
  } pmt_msg_t;
  localparam pmt_msg_t MSG_RESET = '0;
endpackage
`default_nettype wire

// ===== pmt_translator.sv
// message translator between native plc protocol and modbus, with output fifo
//
// Functional notes
// R1 - decode the six native opcodes
// R2 - alarm uses priority write opcode
// R3 - masked write changes only selected bits
// R4 - controllers send only priority peer messages
// R5 - reads to function 3, priority write 16
// R6 - all-ones mask write becomes function 16
// R7 - single register partial contiguous mask: function 22
// R8 - other native commands wrapped in 17
// R9 - function 17 with parameter is wrapped
// R10 - coil/input reads to priority read, status
// R11 - functions 3/4 to non-priority read
// R12 - single coil force to masked write
// R13 - functions 6 and 16 transnum status
// R14 - multiple coils in one register masked
// R15 - function 22 to masked native write
// R16 - function 100 to random read
// R17 - untranslatable modbus wrapped in print BAD5
// R18 - wrapped modbus replies use print reply
// R19 - address byte sent zero, ignored received
// R20 - plain modbus target: only 3/16/22/100
// R21 - modbus ports reject wrapped native messages
// R22 - native ports reject wrapped modbus messages
// R23 - transparent ports forward everything unchanged
// R24 - replies mapped back to originator form
`timescale 1ns/1ps
`default_nettype none

// plain synchronous fifo
module pmt_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         wr_valid,
  output logic              wr_ready,
  input  wire logic [W-1:0] wr_data,
  output logic              rd_valid,
  input  wire logic         rd_ready,
  output logic [W-1:0]      rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];   // storage
  logic [AW-1:0] wr_ptr;       // next write slot
  logic [AW-1:0] rd_ptr;       // next read slot
  logic [AW:0]   level;        // words held
  logic          do_wr;        // push this cycle
  logic          do_rd;        // pop this cycle

  assign wr_ready = (level != (AW+1)'(DEPTH));
  assign rd_valid = (level != '0);
  assign rd_data  = mem[rd_ptr];
  assign do_wr    = wr_valid && wr_ready;
  assign do_rd    = rd_valid && rd_ready;

  // storage is not reset; level guards its contents
  always_ff @(posedge core_clk)
  begin
    if (do_wr)
      mem[wr_ptr] <= wr_data;
  end
  // pointers wrap; depth is a power of two
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
  // fill level, push and pop may coincide
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      level <= '0;
    else if (do_wr && !do_rd)
      level <= level + 1'b1;
    else if (do_rd && !do_wr)
      level <= level - 1'b1;
  end
endmodule // pmt_fifo

// translator top
module pmt_translator
  import pmt_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      rst,
  input  wire pmt_mode_t port_mode,
  input  wire logic      target_is_modbus,
  input  wire logic      in_valid,
  output logic           in_ready,
  input  wire pmt_msg_t  in_msg,
  output logic           out_valid,
  input  wire logic      out_ready,
  output pmt_msg_t       out_msg,
  output logic           wrap_pulse,
  output logic           error_pulse
);

  // true when mask is one run of ones
  function automatic logic contiguous(input logic [15:0] m);
    logic [15:0] low;
    logic [15:0] sum;
    low = m & (~m + 16'h0001);
    sum = m + low;
    contiguous = (m != '0) && ((sum & m) == '0);
  endfunction
  // mask of count coils from bit position pos
  function automatic logic [15:0] coil_mask(input logic [3:0] pos, input logic [3:0] cnt);
    logic [16:0] run;
    run = (17'h00001 << cnt) - 17'h00001;
    coil_mask = 16'(run << pos);
  endfunction
  // build a locally produced error answer
  function automatic pmt_msg_t err_reply(input pmt_msg_t m);
    pmt_msg_t r;
    r           = m;
    r.reply     = 1'b1;
    r.error     = 1'b1;
    r.wrapped   = 1'b1;
    r.addr_byte = WRAP_ADDR_TX;                     // [R19]
    if (m.from_mb)
    begin
      r.code      = MB_WRAP;                        // [R8]
      r.has_param = 1'b1;
      r.param     = WRAP_RPL_PARAM;                 // [R8]
    end
    else
    begin
      r.code   = NAT_PRINT_REPLY;                   // [R18]
      r.status = WRAP_STATUS;                       // [R18]
    end
    err_reply = r;
  endfunction
  // wrap a modbus message into a native print
  function automatic pmt_msg_t wrap_mb(input pmt_msg_t m);
    pmt_msg_t r;
    r           = m;
    r.code      = NAT_PRI_PRINT;                    // [R17]
    r.status    = WRAP_STATUS;                      // [R17]
    r.addr_byte = WRAP_ADDR_TX;                     // [R19]
    r.wrapped   = 1'b1;
    wrap_mb     = r;
  endfunction
  // native query toward a modbus port
  function automatic pmt_msg_t nat_to_mb(input pmt_msg_t m);
    pmt_msg_t r;
    r = m;
    case (m.code)
      NAT_PRI_READ, NAT_NP_READ:                    // [R1] [R4]
        r.code = MB_RD_HOLD;                        // [R5]
      NAT_PRI_WRITE:                                // alarm shares this code [R2]
      begin
        r.code = MB_WR_MULTI;                       // [R5]
        r.mask = MASK_ALL;                          // no mask on priority write [R3]
      end
      NAT_NP_WRITE:                                 // [R1]
      begin
        if (m.mask == MASK_ALL)
          r.code = MB_WR_MULTI;                     // [R6]
        else if (m.count == COUNT_ONE && contiguous(m.mask))
        begin
          r.code = MB_MASK_WR;                      // [R7]
          r.data = m.data & m.mask;                 // unselected data bits cleared [R3]
        end
        else
        begin
          r.code      = MB_WRAP;                    // [R8]
          r.has_param = 1'b1;
          r.param     = WRAP_QRY_PARAM;
          r.wrapped   = 1'b1;
        end
      end
      default:                                      // random read, print, others
      begin
        r.code      = MB_WRAP;                      // [R8]
        r.has_param = 1'b1;
        r.param     = WRAP_QRY_PARAM;               // [R8]
        r.wrapped   = 1'b1;
      end
    endcase
    nat_to_mb = r;
  endfunction
  // modbus query toward the native side
  function automatic pmt_msg_t mb_to_nat(input pmt_msg_t m, input logic tmb);
    pmt_msg_t   r;
    logic [4:0] span;
    logic       ok;
    r    = m;
    span = 5'(m.start[3:0]) + 5'(m.count[3:0]);
    // plain modbus target keeps only four functions [R20]
    ok   = !tmb || m.code == MB_RD_HOLD || m.code == MB_WR_MULTI ||
           m.code == MB_MASK_WR || m.code == MB_RAND_RD;
    if (!ok)
      r = wrap_mb(m);                               // [R20]
    else
    begin
      case (m.code)
        MB_RD_COILS, MB_RD_INPUTS:
        begin
          r.code   = NAT_PRI_READ;                  // [R10]
          r.status = {m.start[3:0], m.count[3:0], (m.code == MB_RD_COILS) ? STAT_COIL_SFX : STAT_INPUT_SFX}; // [R10]
        end
        MB_RD_HOLD, MB_RD_INREG:
        begin
          r.code   = NAT_NP_READ;                   // [R11]
          r.status = 16'(m.code);                   // [R11]
        end
        MB_FORCE_COIL:
        begin
          r.code   = NAT_NP_WRITE;                  // [R12]
          r.status = 16'(m.code);
          r.mask   = coil_mask(m.start[3:0], 4'h1); // exactly one bit [R12]
          r.count  = COUNT_ONE;
        end
        MB_PRESET_REG, MB_WR_MULTI:
        begin
          r.code   = NAT_NP_WRITE;                  // [R13]
          r.status = 16'(m.code);                   // [R13]
        end
        MB_FORCE_COILS:
        begin
          // coils must stay inside one register
          if (m.count != '0 && m.count < REG_BITS && span <= 5'(REG_BITS))
          begin
            r.code   = NAT_NP_WRITE;                // [R14]
            r.status = 16'(m.code);                 // [R14]
            r.mask   = coil_mask(m.start[3:0], m.count[3:0]); // [R14]
            r.count  = COUNT_ONE;
          end
          else
            r = wrap_mb(m);                         // [R17]
        end
        MB_MASK_WR:
        begin
          r.code   = NAT_NP_WRITE;                  // [R15]
          r.status = 16'(MB_WR_MULTI);              // [R15]
        end
        MB_RAND_RD:
          r.code = NAT_NP_RREAD;                    // [R16]
        default:
          r = wrap_mb(m);                           // [R17]
      endcase
    end
    mb_to_nat = r;
  endfunction
  // full translation of one descriptor
  function automatic pmt_msg_t xlate(input pmt_msg_t m, input pmt_mode_t mode,
                                     input logic tmb, input logic [8:0] orig);
    pmt_msg_t r;
    logic     mb_port;
    logic     wrapped_mb;
    logic     wrapped_nat;
    r           = m;
    mb_port     = (mode == PMT_PORT_MB_GATE) || (mode == PMT_PORT_MB_HOST);
    wrapped_mb  = (m.code == NAT_PRI_PRINT) && (m.status == WRAP_STATUS);
    wrapped_nat = (m.code == MB_WRAP) && m.has_param; // [R9]
    if (mode == PMT_PORT_PASS)
      r = m;                                        // [R23]
    else if (m.reply)
    begin
      r.code      = orig[7:0];                      // [R24]
      r.wrapped   = orig[8];
      r.has_param = 1'b0;
      r.addr_byte = WRAP_ADDR_TX;                   // received byte ignored [R19]
    end
    else if (!m.from_mb)
    begin
      if (mode == PMT_PORT_NATIVE && wrapped_mb)
        r = err_reply(m);                           // [R22]
      else if (mb_port)
        r = nat_to_mb(m);
    end
    else if (mb_port)
    begin
      if (wrapped_nat)
        r = err_reply(m);                           // [R21]
      else
        r = mb_to_nat(m, tmb);
    end
    xlate = r;
  endfunction
  logic       stage_valid;    // translated word waiting
  pmt_msg_t   stage_msg;      // translated word
  logic       capture;        // input accepted
  logic       push;           // stage into fifo
  logic       next_stage_v;   // stage occupancy next
  pmt_msg_t   next_msg;       // translation of input
  logic [8:0] orig_tab [TAG_N]; // original code per tag
  logic       fifo_ready;     // fifo space
  logic       fifo_valid;     // fifo has data
  pmt_msg_t   fifo_data;      // fifo head
  logic       load_out;       // fifo head to output
  assign capture      = in_valid && in_ready;
  assign push         = stage_valid && fifo_ready;
  assign next_stage_v = (stage_valid && !push) || capture;
  assign next_msg     = xlate(in_msg, port_mode, target_is_modbus, orig_tab[in_msg.tag]);
  assign load_out     = fifo_valid && (!out_valid || out_ready);
  // ready is registered, so the stage accepts every other cycle at best
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      in_ready    <= 1'b0;
      stage_valid <= 1'b0;
    end
    else
    begin
      in_ready    <= !next_stage_v;
      stage_valid <= next_stage_v;
    end
  end

  // stage data
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      stage_msg <= MSG_RESET;
    else if (capture)
      stage_msg <= next_msg;
  end
  // remember each query's original code for the answer path
  genvar gi;
  generate
    for (gi = 0; gi < TAG_N; gi++)
    begin : g_orig
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
          orig_tab[gi] <= '0;
        else if (capture && !in_msg.reply && !next_msg.reply && in_msg.tag == TAG_W'(gi))
          orig_tab[gi] <= {next_msg.wrapped, in_msg.code}; // [R24]
      end
    end
  endgenerate
  // event pulses, one cycle after capture
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wrap_pulse  <= 1'b0;
      error_pulse <= 1'b0;
    end
    else
    begin
      wrap_pulse  <= capture && next_msg.wrapped && !next_msg.error;
      error_pulse <= capture && next_msg.error;
    end
  end
  // the fifo absorbs stalls on the output side
  pmt_fifo #(
    .W     ($bits(pmt_msg_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_valid (stage_valid),
    .wr_ready (fifo_ready),
    .wr_data  (stage_msg),
    .rd_valid (fifo_valid),
    .rd_ready (load_out),
    .rd_data  (fifo_data)
  );
  // registered output slot
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_msg   <= MSG_RESET;
    end
    else if (load_out)
    begin
      out_valid <= 1'b1;
      out_msg   <= fifo_data;
    end
    else if (out_ready)
      out_valid <= 1'b0;
  end
endmodule // pmt_translator
`default_nettype wire

// ===== pmt_translator_monitor.sv
// concurrent checks on the translator ports
`timescale 1ns/1ps
`default_nettype none
module pmt_translator_monitor
  import pmt_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      rst,
  input  wire pmt_mode_t port_mode,
  input  wire logic      target_is_modbus,
  input  wire logic      in_valid,
  input  wire logic      in_ready,
  input  wire pmt_msg_t  in_msg,
  input  wire logic      out_valid,
  input  wire logic      out_ready,
  input  wire pmt_msg_t  out_msg,
  input  wire logic      wrap_pulse,
  input  wire logic      error_pulse
);
  logic [4:0] pend; // units taken and not yet popped

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // running balance of takes against pops; stage, fifo and out register hold ten at most
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pend <= 5'h00;
    else
      pend <= pend + 5'(in_valid && in_ready) - 5'(out_valid && out_ready);
  end

  sequence s_take;
    in_valid && in_ready;
  endsequence
  sequence s_quiet;
    !wrap_pulse && !error_pulse;
  endsequence

  property p_ready_gap;
    s_take |=> !in_ready;
  endproperty
  a_ready_gap: assert property (p_ready_gap) else $error("in_ready high right after a take");

  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_msg);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved while stalled");

  property p_answer;
    s_take ##0 !out_valid |-> ##[1:3] out_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("no output within three edges");

  property p_pairing;
    out_valid |-> pend != 5'h00 && pend <= 5'h0A;
  endproperty
  a_pairing: assert property (p_pairing) else $error("output without a taken unit");

  property p_pulse_src;
    wrap_pulse || error_pulse |-> $past(in_valid && in_ready);
  endproperty
  a_pulse_src: assert property (p_pulse_src) else $error("pulse without a take");

  property p_one_pulse;
    wrap_pulse |=> !wrap_pulse;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("wrap pulse longer than one cycle");

  property p_err_mode;
    error_pulse |-> !wrap_pulse && $past(port_mode) != PMT_PORT_PASS;
  endproperty
  a_err_mode: assert property (p_err_mode) else $error("error reply in pass mode");

  property p_pass_quiet;
    s_take ##0 port_mode == PMT_PORT_PASS |=> s_quiet;
  endproperty
  a_pass_quiet: assert property (p_pass_quiet) else $error("pass port wrapped a message");

  property p_err_print;
    out_valid && out_msg.error && out_msg.code == NAT_PRINT_REPLY
      |-> out_msg.status == WRAP_STATUS && out_msg.addr_byte == WRAP_ADDR_TX;
  endproperty
  a_err_print: assert property (p_err_print) else $error("print reply lacks marker");

  property p_print_wrap;
    out_valid && out_msg.from_mb && out_msg.wrapped && !out_msg.reply && out_msg.code == NAT_PRI_PRINT
      |-> out_msg.status == WRAP_STATUS && out_msg.addr_byte == WRAP_ADDR_TX;
  endproperty
  a_print_wrap: assert property (p_print_wrap) else $error("print wrap lacks marker");
endmodule // pmt_translator_monitor

bind pmt_translator pmt_translator_monitor pmt_translator_monitor_i (
  .core_clk(core_clk), .rst(rst), .port_mode(port_mode), .target_is_modbus(target_is_modbus),
  .in_valid(in_valid), .in_ready(in_ready), .in_msg(in_msg), .out_valid(out_valid),
  .out_ready(out_ready), .out_msg(out_msg), .wrap_pulse(wrap_pulse), .error_pulse(error_pulse)
);
`default_nettype wire

// ===== pmt_sink_model.sv
// far-side sink model: takes translated units, promptly, slowly or not at all
`timescale 1ns/1ps
`default_nettype none
module pmt_sink_model
  import pmt_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     rst,
  input  wire logic     stall,
  input  wire logic     slow,
  input  wire logic     out_valid,
  output logic          out_ready,
  input  wire pmt_msg_t out_msg,
  output logic          got,
  output pmt_msg_t      got_msg
);
  logic [1:0] pace; // slow mode opens ready one cycle in three

  // ready changes only just after an edge, so the translator sees a clean level
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pace      <= 2'h0;
      out_ready <= 1'b0;
    end
    else
    begin
      pace      <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
      out_ready <= !stall && (!slow || pace == 2'h2);
    end
  end

  // a unit counts where valid and ready meet; the address byte rides along unread
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      got     <= 1'b0;
      got_msg <= MSG_RESET;
    end
    else
    begin
      got     <= out_valid && out_ready;
      got_msg <= out_msg;
    end
  end
endmodule // pmt_sink_model
`default_nettype wire

// ===== pmt_translator_bench.sv
// self-checking bench for the message translator
`timescale 1ns/1ps
`default_nettype none
module pmt_translator_bench
  import pmt_pkg::*;
;
  localparam pmt_mode_t G = PMT_PORT_MB_GATE, H = PMT_PORT_MB_HOST, N = PMT_PORT_NATIVE, P = PMT_PORT_PASS;
  logic      core_clk, rst, target_is_modbus, in_valid, in_ready, out_valid, out_ready;
  logic      wrap_pulse, error_pulse, stall, slow, got;
  pmt_mode_t port_mode;
  pmt_msg_t  in_msg, out_msg, got_msg, m, r;
  pmt_msg_t  rxq[$];           // units seen by the sink, in order
  int        fails = 0;
  int        comparisons = 0;
  int        nw = 0;           // wrap pulses seen
  int        ne = 0;           // error pulses seen

  pmt_translator pmt_translator_i (.core_clk(core_clk), .rst(rst), .port_mode(port_mode),
    .target_is_modbus(target_is_modbus), .in_valid(in_valid), .in_ready(in_ready), .in_msg(in_msg),
    .out_valid(out_valid), .out_ready(out_ready), .out_msg(out_msg), .wrap_pulse(wrap_pulse),
    .error_pulse(error_pulse));
  pmt_sink_model pmt_sink_model_i (.core_clk(core_clk), .rst(rst), .stall(stall), .slow(slow),
    .out_valid(out_valid), .out_ready(out_ready), .out_msg(out_msg), .got(got), .got_msg(got_msg));

  // 50 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // gather sink units and pulse counts
  always @(posedge core_clk)
  begin
    if (got === 1'b1)
      rxq.push_back(got_msg);
    if (wrap_pulse === 1'b1)
      nw++;
    if (error_pulse === 1'b1)
      ne++;
  end

  function automatic pmt_msg_t mk(input logic mb, input logic [7:0] c, input logic [15:0] st, s,
                                  input logic [7:0] n, input logic [15:0] k, d);
    return pmt_msg_t'{from_mb: mb, code: c, status: st, start: s, count: n, mask: k, data: d, default: '0};
  endfunction
  function automatic pmt_msg_t cs(input pmt_msg_t x, input logic [7:0] c, input logic [15:0] st);
    x.code = c;
    x.status = st;
    return x;
  endfunction
  function automatic pmt_msg_t cm(input pmt_msg_t x, input logic [15:0] k, input logic [7:0] n);
    x.mask = k;
    x.count = n;
    return x;
  endfunction
  // flags are reply, error, wrapped, has_param
  function automatic pmt_msg_t wp(input pmt_msg_t x, input logic [3:0] f, input logic [7:0] p);
    {x.reply, x.error, x.wrapped, x.has_param} = f;
    x.param = p;
    x.addr_byte = 8'h00;
    return x;
  endfunction
  function automatic pmt_msg_t wn(input pmt_msg_t x);
    return wp(cs(x, 8'h11, x.status), 4'h3, 8'h01);
  endfunction
  function automatic pmt_msg_t pw(input pmt_msg_t x);
    return wp(cs(x, 8'h22, 16'hBAD5), 4'h2, 8'h00);
  endfunction

  task automatic chk_msg(input pmt_msg_t g, x);
    comparisons++;
    if (g !== x)
    begin
      fails++;
      $display("unexpected at %0t: unit %h, wanted %h", $time, g, x);
    end
  endtask
  task automatic chk_n(input int g, x);
    comparisons++;
    if (g != x)
    begin
      fails++;
      $display("unexpected at %0t: count %0d, wanted %0d", $time, g, x);
    end
  endtask

  // hold the request until an edge samples ready high, then release
  task automatic send(input pmt_msg_t x);
    in_msg <= x;
    in_valid <= 1'b1;
    @(posedge core_clk);
    while (in_ready !== 1'b1)
      @(posedge core_clk);
    in_valid <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic pull(input pmt_msg_t x);
    repeat (60)
      if (rxq.size() == 0)
        @(posedge core_clk);
    if (rxq.size() == 0)
      chk_n(0, 1);
    else
      chk_msg(rxq.pop_front(), x);
  endtask
  // one unit through, with its expected result and pulse counts
  task automatic t(input pmt_mode_t md, input logic tm, input pmt_msg_t x, y, input int w, er);
    int w0, e0;
    w0 = nw;
    e0 = ne;
    port_mode <= md;
    target_is_modbus <= tm;
    send(x);
    pull(y);
    chk_n(nw - w0, w);
    chk_n(ne - e0, er);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic complete_run();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // cut a hang short
  initial
  begin
    repeat (4000) @(posedge core_clk);
    fails++;
    $display("unexpected at %0t: run did not finish", $time);
    complete_run();
  end

  initial
  begin
    rst = 1'b1;
    in_valid = 1'b0;
    in_msg = MSG_RESET;
    port_mode = P;
    target_is_modbus = 1'b0;
    stall = 1'b0;
    slow = 1'b0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    m = mk(0, 8'h20, 16'h1, 16'h5, 8'h2, 16'h0, 16'h0);
    t(G, 0, m, cs(m, 8'h03, 16'h1), 0, 0);
    m.code = 8'h00;
    t(G, 0, m, cs(m, 8'h03, 16'h1), 0, 0);
    m.code = 8'h1E;
    t(G, 0, m, cm(cs(m, 8'h10, 16'h1), 16'hFFFF, 8'h2), 0, 0);
    m = mk(0, 8'h02, 16'h1, 16'h5, 8'h3, 16'hFFFF, 16'h1234);
    t(G, 0, m, cs(m, 8'h10, 16'h1), 0, 0);
    m = mk(0, 8'h02, 16'h1, 16'h5, 8'h1, 16'h00F0, 16'h1234);
    r = cs(m, 8'h16, 16'h1);
    r.data = 16'h0030;
    t(H, 0, m, r, 0, 0);
    m.mask = 16'h0F0F;
    t(G, 0, m, wn(m), 1, 0);
    m.code = 8'h04;
    t(G, 0, m, wn(m), 1, 0);
    m.code = 8'h22;
    t(H, 0, m, wn(m), 1, 0);
    done("native side");
    m = mk(1, 8'h01, 16'h0, 16'h13, 8'h5, 16'h0, 16'h0);
    t(H, 0, m, cs(m, 8'h20, 16'h3503), 0, 0);
    m.code = 8'h02;
    t(G, 0, m, cs(m, 8'h20, 16'h3505), 0, 0);
    m.code = 8'h03;
    t(G, 0, m, cs(m, 8'h00, 16'h3), 0, 0);
    m.code = 8'h04;
    t(G, 0, m, cs(m, 8'h00, 16'h4), 0, 0);
    m = mk(1, 8'h05, 16'h0, 16'h22, 8'h1, 16'h0, 16'hFF00);
    t(G, 0, m, cm(cs(m, 8'h02, 16'h5), 16'h0004, 8'h1), 0, 0);
    m.code = 8'h06;
    t(G, 0, m, cs(m, 8'h02, 16'h6), 0, 0);
    m.code = 8'h10;
    t(G, 0, m, cs(m, 8'h02, 16'h10), 0, 0);
    m = mk(1, 8'h0F, 16'h0, 16'h0C, 8'h4, 16'h0, 16'hF000);
    t(G, 0, m, cm(cs(m, 8'h02, 16'h0F), 16'hF000, 8'h1), 0, 0);
    m.start = 16'h0D;
    t(G, 0, m, pw(m), 1, 0);
    m = mk(1, 8'h16, 16'h0, 16'h3, 8'h1, 16'h00FF, 16'h0012);
    t(G, 0, m, cs(m, 8'h02, 16'h10), 0, 0);
    m.code = 8'h64;
    t(G, 0, m, cs(m, 8'h04, 16'h0), 0, 0);
    m.code = 8'h08;
    m.addr_byte = 8'h05;
    t(G, 0, m, pw(m), 1, 0);
    m = wp(mk(1, 8'h11, 16'h0, 16'h3, 8'h1, 16'h0, 16'h0), 4'h1, 8'h01);
    t(H, 0, m, wp(m, 4'hF, 8'h02), 0, 1);
    done("modbus side");
    m = mk(1, 8'h01, 16'h0, 16'h3, 8'h1, 16'h0, 16'h0);
    t(G, 1, m, pw(m), 1, 0);
    m.code = 8'h06;
    t(G, 1, m, pw(m), 1, 0);
    m.code = 8'h03;
    t(G, 1, m, cs(m, 8'h00, 16'h3), 0, 0);
    m.code = 8'h16;
    t(G, 1, m, cs(m, 8'h02, 16'h10), 0, 0);
    done("plain target");
    m = mk(0, 8'h22, 16'hBAD5, 16'h0, 8'h1, 16'h0, 16'h0);
    t(N, 0, m, wp(cs(m, 8'h92, 16'hBAD5), 4'hE, 8'h00), 0, 1);
    m = mk(1, 8'h03, 16'h0, 16'h3, 8'h1, 16'h0, 16'h0);
    t(N, 0, m, m, 0, 0);
    m.code = 8'h08;
    t(P, 0, m, m, 0, 0);
    m = mk(0, 8'h02, 16'h1, 16'h5, 8'h1, 16'h0F0F, 16'h0);
    t(P, 0, m, m, 0, 0);
    done("port modes");
    slow <= 1'b1;
    m = mk(1, 8'h03, 16'h0, 16'h7, 8'h2, 16'h0, 16'h0);
    m.tag = 3'h2;
    t(G, 0, m, cs(m, 8'h00, 16'h3), 0, 0);
    r = mk(0, 8'h00, 16'h3, 16'h7, 8'h2, 16'h0, 16'hABCD);
    r.reply = 1'b1;
    r.tag = 3'h2;
    t(G, 0, r, cs(r, 8'h03, 16'h3), 0, 0);
    slow <= 1'b0;
    done("reply");
    stall <= 1'b1;
    port_mode <= P;
    for (int i = 0; i < 10; i++)
      send(mk(0, 8'h20, 16'h0, 16'(i), 8'h1, 16'h0, 16'h0));
    in_msg <= mk(0, 8'h20, 16'h0, 16'hA, 8'h1, 16'h0, 16'h0);
    in_valid <= 1'b1;
    repeat (6)
    begin
      @(posedge core_clk);
      chk_n(int'(in_ready === 1'b1), 0);
    end
    stall <= 1'b0;
    send(mk(0, 8'h20, 16'h0, 16'hA, 8'h1, 16'h0, 16'h0));
    for (int i = 0; i < 11; i++)
      pull(mk(0, 8'h20, 16'h0, 16'(i), 8'h1, 16'h0, 16'h0));
    done("fill and drain");
    complete_run();
  end
endmodule // pmt_translator_bench
`default_nettype wire
